// File: src/gpio_port_pkg.sv
// Shared constants for the parallel I/O port with stop-mode retention
package gpio_port_pkg;
  localparam int        PORT_W        = 8;
  localparam int        DRIVE_W       = 7;
  localparam int        ADDR_W        = 2;
  // Register indices on the CPU register port
  localparam logic [1:0] REG_DATA     = 2'h0;
  localparam logic [1:0] REG_DIR      = 2'h1;
  localparam logic [1:0] REG_DRIVE    = 2'h2;
  localparam logic [1:0] REG_PWR      = 2'h3;
  // Field positions in power_mode_status_ctrl_two
  localparam int        PWR_FLAG_BIT  = 3;
  localparam int        PWR_ACK_BIT   = 2;
  // Reset values
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [6:0] DRIVE_RST    = 7'h00;
  localparam logic [7:0] RDATA_RST    = 8'h00;
endpackage : gpio_port_pkg

// File: src/pin_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import gpio_port_pkg::*;
(
  input  wire logic              clk_sys_i,  // System clock
  input  wire logic              srst_i,     // Synchronous reset, active high
  input  wire logic              ce_i,       // Clock enable
  input  wire logic [PORT_W-1:0] async_i,    // Raw pin levels
  output logic      [PORT_W-1:0] sync_o      // Synchronised pin levels
);
  logic [PORT_W-1:0] meta_reg;
  logic [PORT_W-1:0] meta_next;
  logic [PORT_W-1:0] sync_reg;
  logic [PORT_W-1:0] sync_next;

  genvar b;
  generate
    for (b = 0; b < PORT_W; b++) begin : g_bit
      // First stage feeds only the second stage
      always_comb begin
        meta_next[b] = ce_i ? async_i[b] : meta_reg[b];
        sync_next[b] = ce_i ? meta_reg[b] : sync_reg[b];
      end
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          meta_reg[b] <= 1'b0;
          sync_reg[b] <= 1'b0;
        end else begin
          meta_reg[b] <= meta_next[b];
          sync_reg[b] <= sync_next[b];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;
endmodule : pin_sync
`default_nettype wire

// File: src/parallel_io_port_stop_retention.sv
// Parallel I/O port with data latch, direction, drive strength and stop retention
`timescale 1ns/100ps
`default_nettype none
module parallel_io_port_stop_retention
  import gpio_port_pkg::*;
(
  input  wire logic               clk_sys_i,     // System clock, 100 MHz
  input  wire logic               srst_i,        // Synchronous reset, active high
  input  wire logic               ce_i,          // Clock enable, freezes all state when low
  input  wire logic [ADDR_W-1:0]  reg_addr_i,    // Register index
  input  wire logic               reg_wr_i,      // Register write strobe
  input  wire logic               reg_rd_i,      // Register read strobe
  input  wire logic [7:0]         reg_wdata_i,   // Write data
  output logic      [7:0]         reg_rdata_o,   // Read data, valid the cycle after read
  input  wire logic               deep_stop_i,   // High while in deep retention stop
  input  wire logic               light_stop_i,  // High while in light powered stop
  input  wire logic [PORT_W-1:0]  pin_in_i,      // Pin levels from the pads
  output logic      [PORT_W-1:0]  pin_out_o,     // Pin output values
  output logic      [PORT_W-1:0]  pin_oe_o,      // Pin output enables, high drives
  output logic      [DRIVE_W-1:0] drive_high_o,  // High drive select, one bit each for 7 of the 8 pins
  output logic                    pwrdn_flag_o,  // Partial power-down flag
  output logic                    pins_held_o    // Pins held after deep wake
);
  logic [PORT_W-1:0]  pin_level;
  logic [PORT_W-1:0]  latch_reg,   latch_next;
  logic [PORT_W-1:0]  dir_reg,     dir_next;
  logic [DRIVE_W-1:0] strength_reg, strength_next;
  logic [PORT_W-1:0]  pout_reg,    pout_next;
  logic [PORT_W-1:0]  poe_reg,     poe_next;
  logic [DRIVE_W-1:0] phigh_reg,   phigh_next;
  logic [7:0]         rdata_reg,   rdata_next;
  logic               flag_reg,    flag_next;
  logic               hold_reg,    hold_next;
  logic               deep_prev_reg, deep_prev_next;
  logic               bus_ok;
  logic               wake;
  logic               ack_wr;
  logic               freeze;

  pin_sync u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_level)
  );

  // The CPU is halted in either stop, so no register access can arrive then
  assign bus_ok = !deep_stop_i && !light_stop_i;
  assign wake   = deep_prev_reg && !deep_stop_i;
  assign ack_wr = bus_ok && reg_wr_i && (reg_addr_i == REG_PWR) && reg_wdata_i[PWR_ACK_BIT];
  // Pins keep their pre-deep-stop state until software acknowledges
  assign freeze = deep_stop_i || hold_reg || wake;

  always_comb begin
    latch_next     = latch_reg;
    dir_next       = dir_reg;
    strength_next  = strength_reg;
    pout_next      = pout_reg;
    poe_next       = poe_reg;
    phigh_next     = phigh_reg;
    rdata_next     = rdata_reg;
    flag_next      = flag_reg;
    hold_next      = hold_reg;
    deep_prev_next = deep_prev_reg;
    if (ce_i) begin
      deep_prev_next = deep_stop_i;
      if (bus_ok && reg_wr_i) begin
        unique case (reg_addr_i)
          REG_DATA:  latch_next    = reg_wdata_i;
          REG_DIR:   dir_next      = reg_wdata_i;
          REG_DRIVE: strength_next = reg_wdata_i[DRIVE_W-1:0];
          REG_PWR:   ;
        endcase
      end
      if (bus_ok && reg_rd_i) begin
        unique case (reg_addr_i)
          REG_DATA:  rdata_next = (dir_reg & latch_reg) | (~dir_reg & pin_level);
          REG_DIR:   rdata_next = dir_reg;
          REG_DRIVE: rdata_next = {1'b0, strength_reg};
          REG_PWR: begin
            rdata_next               = RDATA_RST;
            rdata_next[PWR_FLAG_BIT] = flag_reg;
          end
        endcase
      end
      // Acknowledge clears, but a wake in the same cycle wins
      if (ack_wr) begin
        flag_next = 1'b0;
        hold_next = 1'b0;
      end
      if (wake) begin
        flag_next = 1'b1;
        hold_next = 1'b1;
      end
      // Light stop does not freeze the pins, the logic stays powered
      if (!freeze) begin
        pout_next  = latch_reg;
        poe_next   = dir_reg;
        phigh_next = strength_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      latch_reg     <= DATA_RST;
      dir_reg       <= DIR_RST;
      strength_reg  <= DRIVE_RST;
      pout_reg      <= DATA_RST;
      poe_reg       <= DIR_RST;
      phigh_reg     <= DRIVE_RST;
      rdata_reg     <= RDATA_RST;
      flag_reg      <= 1'b0;
      hold_reg      <= 1'b0;
      deep_prev_reg <= 1'b0;
    end else begin
      latch_reg     <= latch_next;
      dir_reg       <= dir_next;
      strength_reg  <= strength_next;
      pout_reg      <= pout_next;
      poe_reg       <= poe_next;
      phigh_reg     <= phigh_next;
      rdata_reg     <= rdata_next;
      flag_reg      <= flag_next;
      hold_reg      <= hold_next;
      deep_prev_reg <= deep_prev_next;
    end
  end

  assign reg_rdata_o  = rdata_reg;
  assign pin_out_o    = pout_reg;
  assign pin_oe_o     = poe_reg;
  assign drive_high_o = phigh_reg;
  assign pwrdn_flag_o = flag_reg;
  assign pins_held_o  = hold_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  chk_latch_write: assert property (
    ce_i && bus_ok && reg_wr_i && reg_addr_i == REG_DATA |=> latch_reg == $past(reg_wdata_i))
    else $error("data latch not updated by write");

  chk_read_input: assert property (
    ce_i && bus_ok && reg_rd_i && reg_addr_i == REG_DATA
    |=> (reg_rdata_o & ~$past(dir_reg)) == ($past(pin_level) & ~$past(dir_reg)))
    else $error("input bit read does not show pin level");

  chk_read_output: assert property (
    ce_i && bus_ok && reg_rd_i && reg_addr_i == REG_DATA
    |=> (reg_rdata_o & $past(dir_reg)) == ($past(latch_reg) & $past(dir_reg)))
    else $error("output bit read does not show latch");

  chk_drive_follow: assert property (
    ce_i && !freeze |=> pin_out_o == $past(latch_reg) && pin_oe_o == $past(dir_reg))
    else $error("pins do not follow latch and direction");

  chk_deep_retain: assert property (
    (ce_i && deep_stop_i) ##1 (ce_i && deep_stop_i) ##1 ce_i && !deep_stop_i
    |=> $stable(pin_out_o) && $stable(pin_oe_o) && pins_held_o)
    else $error("pin state lost across deep stop");

  chk_flag_on_wake: assert property (
    ce_i && wake |=> pwrdn_flag_o && pins_held_o)
    else $error("flag not set on deep wake");

  chk_ack_release: assert property (
    ce_i && ack_wr && !wake |=> !pwrdn_flag_o && !pins_held_o)
    else $error("acknowledge did not release");

  chk_light_no_hold: assert property (
    ce_i && light_stop_i && !deep_stop_i && !pins_held_o && !wake |=> !pins_held_o)
    else $error("light stop held the pins");

  chk_reset_state: assert property (disable iff (1'b0)
    srst_i |=> latch_reg == DATA_RST && pin_oe_o == DIR_RST)
    else $error("reset state wrong");

  chk_strength_out: assert property (
    ce_i && !freeze |=> drive_high_o == $past(strength_reg))
    else $error("drive strength not applied");

  chk_dir_write: assert property (
    ce_i && bus_ok && reg_wr_i && reg_addr_i == REG_DIR |=> dir_reg == $past(reg_wdata_i))
    else $error("direction not updated by write");

  // Held pins ignore restore writes until the acknowledge lands
  chk_held_frozen: assert property (
    pins_held_o |=> $stable(pin_out_o) && $stable(pin_oe_o) && $stable(drive_high_o))
    else $error("held pins changed before acknowledge");

  chk_flag_sticky: assert property (
    pwrdn_flag_o && !(ce_i && ack_wr) |=> pwrdn_flag_o)
    else $error("flag cleared without acknowledge");

  chk_flag_read: assert property (
    ce_i && bus_ok && reg_rd_i && reg_addr_i == REG_PWR
    |=> reg_rdata_o[PWR_FLAG_BIT] == $past(flag_reg))
    else $error("flag read does not show flag");

  chk_rdata_hold: assert property (
    !(ce_i && bus_ok && reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  chk_ce_freeze: assert property (
    !ce_i |=> $stable(pin_out_o) && $stable(pin_oe_o) && $stable(drive_high_o)
          && $stable(reg_rdata_o) && $stable(pwrdn_flag_o) && $stable(pins_held_o))
    else $error("state moved with clock enable low");

  cov_deep_wake: cover property (ce_i && wake);
  cov_ack:       cover property (ce_i && ack_wr && pins_held_o);
  cov_read_mix:  cover property (ce_i && reg_rd_i && reg_addr_i == REG_DATA && dir_reg != DIR_RST);
  cov_light:     cover property (ce_i && light_stop_i);
endmodule : parallel_io_port_stop_retention
`default_nettype wire

// File: sim/pin_board.sv
// Board model that resolves each pad from the port drive and the board drivers
`timescale 1ns/100ps
`default_nettype none
module pin_board
  import gpio_port_pkg::*;
(
  input  wire logic [PORT_W-1:0] pin_out_i, // Port output values
  input  wire logic [PORT_W-1:0] pin_oe_i,  // Port output enables
  input  wire logic [PORT_W-1:0] ext_i,     // Board driver levels
  output logic      [PORT_W-1:0] pad_o      // Resolved pad levels
);
  // Board drives only released pins, so the two sides never fight
  assign pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule : pin_board
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the parallel port with stop retention
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import gpio_port_pkg::*;
;
  logic       clk_sys_i = 1'b0;
  logic       srst_i    = 1'b1;
  logic       ce        = 1'b1;
  logic [1:0] addr      = 2'h0;
  logic       wr_en     = 1'b0;
  logic       rd_en     = 1'b0;
  logic [7:0] wdata     = 8'h00;
  logic       deep      = 1'b0;
  logic       light     = 1'b0;
  logic [7:0] ext       = 8'h5a;
  logic [7:0] rdata, pad, pout, poe;
  logic [6:0] drv;
  logic       flag, held;
  int         num_errors   = 0;
  int         total_checks = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  parallel_io_port_stop_retention i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .deep_stop_i(deep), .light_stop_i(light),
    .pin_in_i(pad), .pin_out_o(pout), .pin_oe_o(poe), .drive_high_o(drv),
    .pwrdn_flag_o(flag), .pins_held_o(held));
  pin_board i_board (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext), .pad_o(pad));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys_i);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys_i);
    rd_en <= 1'b0;
    cyc(1);
    chk("reg_rdata", exp, rdata);
  endtask : rdchk

  task automatic pins(input logic [7:0] o, input logic [7:0] e);
    chk("pin_out", o, pout);
    chk("pin_oe", e, poe);
  endtask : pins

  task automatic t_reset;
    cyc(1);
    pins(8'h00, 8'h00);
    rdchk(REG_DIR, 8'h00);
    rdchk(REG_DRIVE, 8'h00);
    rdchk(REG_PWR, 8'h00);
    wr(REG_DIR, 8'hff);
    cyc(2);
    pins(8'h00, 8'hff);
    wr(REG_DIR, 8'h00);
  endtask : t_reset

  task automatic t_data;
    wr(REG_DATA, 8'hc3);
    rdchk(REG_DATA, 8'h5a);
    wr(REG_DIR, 8'hf0);
    cyc(2);
    pins(8'hc3, 8'hf0);
    rdchk(REG_DATA, 8'hca);
    // Synchronised pin levels still show the old value here, so only the latch can give 3a
    wr(REG_DATA, 8'h3c);
    rdchk(REG_DATA, 8'h3a);
    wr(REG_DATA, 8'hc3);
  endtask : t_data

  task automatic t_drive;
    wr(REG_DRIVE, 8'hff);
    cyc(2);
    chk("drive_high", 8'h7f, {1'b0, drv});
    rdchk(REG_DRIVE, 8'h7f);
    // Clock enable low: this write must be ignored
    @(posedge clk_sys_i);
    ce <= 1'b0;
    wr(REG_DRIVE, 8'h00);
    ce <= 1'b1;
    cyc(2);
    chk("drive_high", 8'h7f, {1'b0, drv});
    rdchk(REG_DRIVE, 8'h7f);
    wr(REG_DRIVE, 8'hd5);
    cyc(2);
    chk("drive_high", 8'h55, {1'b0, drv});
  endtask : t_drive

  task automatic t_light;
    @(posedge clk_sys_i);
    light <= 1'b1;
    cyc(4);
    pins(8'hc3, 8'hf0);
    @(posedge clk_sys_i);
    light <= 1'b0;
    rdchk(REG_DATA, 8'hca);
    chk("flag", 8'h00, {7'h0, flag});
    wr(REG_DATA, 8'h3c);
    cyc(2);
    pins(8'h3c, 8'hf0);
    wr(REG_DATA, 8'hc3);
  endtask : t_light

  task automatic t_deep;
    @(posedge clk_sys_i);
    deep <= 1'b1;
    cyc(4);
    pins(8'hc3, 8'hf0);
    @(posedge clk_sys_i);
    deep <= 1'b0;
    cyc(3);
    chk("flag_held", 8'h03, {6'h0, flag, held});
    rdchk(REG_PWR, 8'h08);
    // Restore with new values; pins must stay frozen until the acknowledge
    wr(REG_DATA, 8'h3c);
    wr(REG_DIR, 8'h0f);
    cyc(2);
    pins(8'hc3, 8'hf0);
    wr(REG_PWR, 8'h04);
    cyc(3);
    chk("flag_held", 8'h00, {6'h0, flag, held});
    pins(8'h3c, 8'h0f);
    rdchk(REG_DATA, 8'h5c);
  endtask : t_deep

  task automatic t_reset_mid;
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    cyc(1);
    chk("flag_held", 8'h00, {6'h0, flag, held});
    pins(8'h00, 8'h00);
    // Latch held 3c before reset; driving all pins shows it cleared
    wr(REG_DIR, 8'hff);
    cyc(2);
    pins(8'h00, 8'hff);
  endtask : t_reset_mid

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset();
    t_data();
    t_drive();
    t_light();
    t_deep();
    t_reset_mid();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
